/* File: sir_top.v */
/*
  Interrupt and transfer-request logic of a three-channel serial
  interface: per-channel flags, request lines, transfer controller
  activation and a fixed-priority encoder toward the processor.
  Assumes the shifters, framing and baud logic deliver one-cycle event
  pulses on clk_sys, and that software clears arrive as pulses too.
  Transfer controllers acknowledge a serviced request with a pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sir_defines.vh"

module sir_top #(
  parameter NUM_CH    = `SIR_NUM_CH,
  parameter DMA_OK    = `SIR_DMA_OK_MASK
) (
  // Clock and reset
  input  wire                      clk_sys,
  input  wire                      rstn,
  // Mode and enables per channel
  input  wire [NUM_CH-1:0]         scMode,
  input  wire [NUM_CH-1:0]         txIrqEnable,
  input  wire [NUM_CH-1:0]         rxIrqEnable,
  input  wire [NUM_CH-1:0]         txEndIrqEnable,
  // Events from the serial engines
  input  wire [NUM_CH-1:0]         txLoadEvt,
  input  wire [NUM_CH-1:0]         txEndEvt,
  input  wire [NUM_CH-1:0]         txErrEvt,
  input  wire [NUM_CH-1:0]         rxFullEvt,
  input  wire [NUM_CH-1:0]         overrunEvt,
  input  wire [NUM_CH-1:0]         parityEvt,
  input  wire [NUM_CH-1:0]         framingEvt,
  input  wire [NUM_CH-1:0]         errSignalEvt,
  // Software clear strobes
  input  wire [NUM_CH-1:0]         clrTxEmpty,
  input  wire [NUM_CH-1:0]         clrTxEnd,
  input  wire [NUM_CH-1:0]         clrRxFull,
  input  wire [NUM_CH-1:0]         clrOverrun,
  input  wire [NUM_CH-1:0]         clrParity,
  input  wire [NUM_CH-1:0]         clrFraming,
  input  wire [NUM_CH-1:0]         clrErrSignal,
  // Transfer routing and acknowledge
  input  wire [NUM_CH-1:0]         rxXferSel,
  input  wire [NUM_CH-1:0]         txXferSel,
  input  wire [NUM_CH-1:0]         dmaSel,
  input  wire [NUM_CH-1:0]         xferRxAck,
  input  wire [NUM_CH-1:0]         xferTxAck,
  // Flag state
  output wire [NUM_CH-1:0]         txBufferEmptyFlag,
  output wire [NUM_CH-1:0]         txEndFlag,
  output wire [NUM_CH-1:0]         rxBufferFullFlag,
  output wire [NUM_CH-1:0]         overrunErrorFlag,
  output wire [NUM_CH-1:0]         parityErrorFlag,
  output wire [NUM_CH-1:0]         framingErrorFlag,
  output wire [NUM_CH-1:0]         errorSignalFlag,
  output wire [NUM_CH-1:0]         resendBusy,
  // Request lines
  output wire [NUM_CH-1:0]         rxErrorRequest,
  output wire [NUM_CH-1:0]         rxFullRequest,
  output wire [NUM_CH-1:0]         txEmptyRequest,
  output wire [NUM_CH-1:0]         txEndRequest,
  // Transfer controller starts
  output wire [NUM_CH-1:0]         dataXferRxStart,
  output wire [NUM_CH-1:0]         dataXferTxStart,
  output wire [NUM_CH-1:0]         dmaRxStart,
  output wire [NUM_CH-1:0]         dmaTxStart,
  // Processor interrupt
  output reg                       irqValid_q,
  output reg  [`SIR_VEC_W-1:0]     irqVector_q
);

  localparam NSRC = NUM_CH * `SIR_REQS_PER_CH;

  wire [NSRC-1:0]   reqAll;
  wire [NSRC-1:0]   cpuReq;
  wire [NUM_CH-1:0] dmaEff;
  wire [NUM_CH-1:0] rxStart;
  wire [NUM_CH-1:0] txStart;
  wire [NUM_CH-1:0] rxAckEff;
  wire [NUM_CH-1:0] txAckEff;
  reg               irqValid_d;
  reg  [`SIR_VEC_W-1:0] irqVector_d;
  integer           k;

  //////////////////////////////////////////////////////////////////////////
  // One flag block per channel
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : gCh
      wire [`SIR_REQS_PER_CH-1:0] chReq;

      sir_channel_flags uFlags (
        .clk_sys        (clk_sys),
        .rstn           (rstn),
        .scMode         (scMode[c]),
        .txIrqEnable    (txIrqEnable[c]),
        .rxIrqEnable    (rxIrqEnable[c]),
        .txEndIrqEnable (txEndIrqEnable[c]),
        .txLoadEvt      (txLoadEvt[c]),
        .txEndEvt       (txEndEvt[c]),
        .txErrEvt       (txErrEvt[c]),
        .rxFullEvt      (rxFullEvt[c]),
        .overrunEvt     (overrunEvt[c]),
        .parityEvt      (parityEvt[c]),
        .framingEvt     (framingEvt[c]),
        .errSignalEvt   (errSignalEvt[c]),
        .clrTxEmpty     (clrTxEmpty[c]),
        .clrTxEnd       (clrTxEnd[c]),
        .clrRxFull      (clrRxFull[c]),
        .clrOverrun     (clrOverrun[c]),
        .clrParity      (clrParity[c]),
        .clrFraming     (clrFraming[c]),
        .clrErrSignal   (clrErrSignal[c]),
        .txAck          (txAckEff[c]),
        .rxAck          (rxAckEff[c]),
        .txEmpty_q      (txBufferEmptyFlag[c]),
        .txEnd_q        (txEndFlag[c]),
        .rxFull_q       (rxBufferFullFlag[c]),
        .overrun_q      (overrunErrorFlag[c]),
        .parity_q       (parityErrorFlag[c]),
        .framing_q      (framingErrorFlag[c]),
        .errSignal_q    (errorSignalFlag[c]),
        .resend_q       (resendBusy[c]),
        .req            (chReq)
      );

      // Expose request lines and gather them into one vector
      assign rxErrorRequest[c] = chReq[`SIR_SLOT_ERR];
      assign rxFullRequest[c]  = chReq[`SIR_SLOT_RXFULL];
      assign txEmptyRequest[c] = chReq[`SIR_SLOT_TXEMPTY];
      assign txEndRequest[c]   = chReq[`SIR_SLOT_TXEND];
      assign reqAll[c*`SIR_REQS_PER_CH +: `SIR_REQS_PER_CH] = chReq;

      //////////////////////////////////////////////////////////////////////
      // Transfer activation; only rx-full and tx-empty may start one
      assign rxStart[c] = chReq[`SIR_SLOT_RXFULL] & rxXferSel[c];
      assign txStart[c] = chReq[`SIR_SLOT_TXEMPTY] & txXferSel[c];
      // A DMA choice on a channel without DMA falls back to the data transfer controller
      assign dmaEff[c]     = dmaSel[c] & DMA_OK[c];
      assign dmaRxStart[c] = rxStart[c] & dmaEff[c];
      assign dmaTxStart[c] = txStart[c] & dmaEff[c];
      assign dataXferRxStart[c] = rxStart[c] & ~dmaEff[c];
      assign dataXferTxStart[c] = txStart[c] & ~dmaEff[c];

      // Stray acknowledges without an active start are ignored,
      // so a controller cannot wipe a flag it never serviced
      assign rxAckEff[c] = xferRxAck[c] & rxStart[c];
      assign txAckEff[c] = xferTxAck[c] & txStart[c];

      // Sources given to a transfer controller stay off the CPU line
      assign cpuReq[c*`SIR_REQS_PER_CH + `SIR_SLOT_ERR] =
        reqAll[c*`SIR_REQS_PER_CH + `SIR_SLOT_ERR];
      assign cpuReq[c*`SIR_REQS_PER_CH + `SIR_SLOT_RXFULL] =
        reqAll[c*`SIR_REQS_PER_CH + `SIR_SLOT_RXFULL] & ~rxXferSel[c];
      assign cpuReq[c*`SIR_REQS_PER_CH + `SIR_SLOT_TXEMPTY] =
        reqAll[c*`SIR_REQS_PER_CH + `SIR_SLOT_TXEMPTY] & ~txXferSel[c];
      assign cpuReq[c*`SIR_REQS_PER_CH + `SIR_SLOT_TXEND] =
        reqAll[c*`SIR_REQS_PER_CH + `SIR_SLOT_TXEND];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Fixed priority: lowest index wins, scanning down keeps the lowest.
  // Tx-empty sits below tx-end in each channel, so it is taken first.
  always @* begin
    irqValid_d  = 1'b0;
    irqVector_d = {`SIR_VEC_W{1'b0}};
    for (k = NSRC - 1; k >= 0; k = k - 1) begin
      if (cpuReq[k]) begin
        irqValid_d  = 1'b1;
        irqVector_d = k[`SIR_VEC_W-1:0];
      end
    end
  end

  // Registered vector; one cycle behind the request lines
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqValid_q  <= 1'b0;
      irqVector_q <= {`SIR_VEC_W{1'b0}};
    end else begin
      irqValid_q  <= irqValid_d;
      irqVector_q <= irqVector_d;
    end
  end

endmodule // sir_top
`default_nettype wire

/* File: sir_defines.vh */
/*
  Shared constants of the serial interrupt request logic: channel count,
  request slot positions, vector layout and flag reset value.
  Assumes inclusion by bare name from the design files of this block.
*/
// Notes on behaviour
// - Empty buffer and enable raise tx-empty request
// - Tx-end request needs end flag and enable
// - Full receive buffer and enable raise rx-full
// - Normal mode: overrun, parity, framing raise error
// - Each source has vector and own enable; code: error and rx-full share rxIrqEnable
// - Transfer service clears empty flag by itself
// - Rx-full starts transfer; transfer clears full flag
// - Tx-empty wins over tx-end when both pending
// - Channel 2 never starts the DMA controller
// - Smart card: no tx-end; error uses error-signal
// - Smart card: empty flag set with end flag
// - Smart card transfer clears empty and end flags
// - Smart card tx error: resend, end stays 0
// - Error-signal flag clears only by software
// - Smart card rx error: no full flag, CPU informed
`ifndef SIR_DEFINES_VH
`define SIR_DEFINES_VH

// Channel and request layout
`define SIR_NUM_CH       3
`define SIR_REQS_PER_CH  4
`define SIR_NUM_SRC      12
`define SIR_VEC_W        4

// Request slot inside one channel, lowest slot served first
`define SIR_SLOT_ERR     0
`define SIR_SLOT_RXFULL  1
`define SIR_SLOT_TXEMPTY 2
`define SIR_SLOT_TXEND   3

// Channels allowed to start the DMA controller
`define SIR_DMA_OK_MASK  3'h3

// Flag reset values
`define SIR_TXEMPTY_RST  1'b1
`define SIR_TXEND_RST    1'b1
`define SIR_FLAG_RST     1'b0

`endif

/* File: sir_channel_flags.v */
/*
  Status flags and request lines of one serial channel.
  Assumes event and clear strobes are one-cycle pulses from logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sir_defines.vh"

module sir_channel_flags (
  input  wire clk_sys,
  input  wire rstn,
  input  wire scMode,
  input  wire txIrqEnable,
  input  wire rxIrqEnable,
  input  wire txEndIrqEnable,
  input  wire txLoadEvt,
  input  wire txEndEvt,
  input  wire txErrEvt,
  input  wire rxFullEvt,
  input  wire overrunEvt,
  input  wire parityEvt,
  input  wire framingEvt,
  input  wire errSignalEvt,
  input  wire clrTxEmpty,
  input  wire clrTxEnd,
  input  wire clrRxFull,
  input  wire clrOverrun,
  input  wire clrParity,
  input  wire clrFraming,
  input  wire clrErrSignal,
  input  wire txAck,
  input  wire rxAck,
  output reg  txEmpty_q,
  output reg  txEnd_q,
  output reg  rxFull_q,
  output reg  overrun_q,
  output reg  parity_q,
  output reg  framing_q,
  output reg  errSignal_q,
  output reg  resend_q,
  output wire [`SIR_REQS_PER_CH-1:0] req
);

  wire txEmptySet;
  wire txEmptyClr;
  wire txEndSet;
  wire txEndClr;
  wire rxFullSet;
  wire rxErrNow;

  //////////////////////////////////////////////////////////////////////////
  // Set and clear terms; every set wins over a clear in the same cycle
  assign txEmptySet = scMode ? txEndEvt : txLoadEvt;
  assign txEmptyClr = clrTxEmpty | txAck;
  assign txEndSet   = txEndEvt;
  // Retry or smart card service keeps the end flag low
  assign txEndClr   = clrTxEnd | (scMode & (txAck | txErrEvt | resend_q));
  // A receive error in smart card mode must not fill the buffer
  assign rxErrNow   = parityEvt | overrunEvt;
  assign rxFullSet  = rxFullEvt & ~(scMode & rxErrNow);

  // Flag registers
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txEmpty_q   <= `SIR_TXEMPTY_RST;
      txEnd_q     <= `SIR_TXEND_RST;
      rxFull_q    <= `SIR_FLAG_RST;
      overrun_q   <= `SIR_FLAG_RST;
      parity_q    <= `SIR_FLAG_RST;
      framing_q   <= `SIR_FLAG_RST;
      errSignal_q <= `SIR_FLAG_RST;
      resend_q    <= `SIR_FLAG_RST;
    end else begin
      txEmpty_q   <= txEmptySet | (txEmpty_q & ~txEmptyClr);
      txEnd_q     <= txEndSet | (txEnd_q & ~txEndClr);
      rxFull_q    <= rxFullSet | (rxFull_q & ~(clrRxFull | rxAck));
      overrun_q   <= overrunEvt | (overrun_q & ~clrOverrun);
      parity_q    <= parityEvt | (parity_q & ~clrParity);
      framing_q   <= framingEvt | (framing_q & ~clrFraming);
      // No automatic clear: software handler must clear it
      errSignal_q <= errSignalEvt | (errSignal_q & ~clrErrSignal);
      // Held from a smart card tx error until the resend ends
      resend_q    <= (scMode & txErrEvt) | (resend_q & ~txEndEvt);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request lines, each behind an enable; error and rx-full share rxIrqEnable
  assign req[`SIR_SLOT_ERR] = rxIrqEnable & (overrun_q | parity_q |
                              (scMode ? errSignal_q : framing_q));
  assign req[`SIR_SLOT_RXFULL]  = rxIrqEnable & rxFull_q;
  assign req[`SIR_SLOT_TXEMPTY] = txIrqEnable & txEmpty_q;
  assign req[`SIR_SLOT_TXEND]   = txEndIrqEnable & txEnd_q & ~scMode;

endmodule // sir_channel_flags
`default_nettype wire

/* File: sir_monitor.sv */
/* Concurrent checks on the sir_top ports.
   Assumes one clock, clk_sys, and an asynchronous active-low rstn. */
`timescale 1ns/1ps
`default_nettype none
module sir_monitor (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic [2:0] scMode,
  input wire logic [2:0] txIrqEnable,
  input wire logic [2:0] rxIrqEnable,
  input wire logic [2:0] txEndIrqEnable,
  input wire logic [2:0] txLoadEvt,
  input wire logic [2:0] txEndEvt,
  input wire logic [2:0] txErrEvt,
  input wire logic [2:0] xferTxAck,
  input wire logic [2:0] txBufferEmptyFlag,
  input wire logic [2:0] txEndFlag,
  input wire logic [2:0] rxBufferFullFlag,
  input wire logic [2:0] overrunErrorFlag,
  input wire logic [2:0] parityErrorFlag,
  input wire logic [2:0] framingErrorFlag,
  input wire logic [2:0] errorSignalFlag,
  input wire logic [2:0] resendBusy,
  input wire logic [2:0] rxErrorRequest,
  input wire logic [2:0] rxFullRequest,
  input wire logic [2:0] txEmptyRequest,
  input wire logic [2:0] txEndRequest,
  input wire logic [2:0] dataXferTxStart,
  input wire logic [2:0] dmaTxStart,
  input wire logic [2:0] dmaRxStart
);
  // Serviced transmit with no set in the same cycle, since a set wins
  wire [2:0] txClr = (dataXferTxStart | dmaTxStart) & xferTxAck & ~txLoadEvt & ~txEndEvt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_sc_end; scMode[0] && txEndEvt[0]; endsequence
  sequence s_sc_err; scMode[0] && txErrEvt[0] && !txEndEvt[0]; endsequence
  ////////////////////////////////////////
  a_tx_empty_req: assert property (
    txEmptyRequest == (txBufferEmptyFlag & txIrqEnable)) else $error("tx empty request wrong");
  a_tx_end_req: assert property (
    txEndRequest == (txEndFlag & txEndIrqEnable & ~scMode)) else $error("tx end request wrong");
  a_rx_full_req: assert property (
    rxFullRequest == (rxBufferFullFlag & rxIrqEnable)) else $error("rx full request wrong");
  a_rx_err_req: assert property (
    rxErrorRequest == (rxIrqEnable & (overrunErrorFlag | parityErrorFlag
      | (scMode & errorSignalFlag) | (~scMode & framingErrorFlag))))
    else $error("error req wrong");
  a_tx_ack_clr: assert property (
    txClr != 3'h0 |=> (txBufferEmptyFlag & $past(txClr)) == 3'h0
      && (txEndFlag & $past(txClr & scMode)) == 3'h0) else $error("serviced flags kept");
  a_ch2_no_dma: assert property (
    !dmaRxStart[2] && !dmaTxStart[2]) else $error("channel 2 started dma");
  a_sc_end_set: assert property (
    s_sc_end |=> txBufferEmptyFlag[0] && txEndFlag[0]) else $error("smart card end flags wrong");
  a_sc_resend: assert property (
    s_sc_err |=> resendBusy[0] && !txEndFlag[0]) else $error("smart card resend not entered");
endmodule // sir_monitor
bind sir_top sir_monitor u_mon (.*);
`default_nettype wire

/* File: sir_xfer_model.sv */
/* Transfer controller stand-in: acks started transfers after a random
   hold-off. Assumes start levels come straight from sir_top. */
`timescale 1ns/1ps
`default_nettype none
module sir_xfer_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [2:0] dataXferRxStart,
  input  wire logic [2:0] dataXferTxStart,
  input  wire logic [2:0] dmaRxStart,
  input  wire logic [2:0] dmaTxStart,
  output var  logic [2:0] xferRxAck,
  output var  logic [2:0] xferTxAck
);
  logic [7:0] lfsr;
  // Ready from time zero, before the serial side raises anything
  initial begin
    lfsr = 8'h5a;
    xferRxAck = 3'h0;
    xferTxAck = 3'h0;
    forever begin
      @(posedge clk_sys);
      #2;
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      // Random hold-off models a busy controller; a late ack may meet a dropped start
      xferRxAck = {3{rstn}} & (dataXferRxStart | dmaRxStart) & lfsr[2:0];
      xferTxAck = {3{rstn}} & (dataXferTxStart | dmaTxStart) & lfsr[5:3];
    end
  end
endmodule // sir_xfer_model
`default_nettype wire

/* File: sir_tb_top.sv */
/* Random-event bench of sir_top with a flag model checked every cycle.
   Assumes sir_defines.vh, sir_monitor and sir_xfer_model alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "sir_defines.vh"
module sir_tb_top;
  localparam logic [2:0] DOK = `SIR_DMA_OK_MASK;
  logic clk_sys = 1'b0;
  logic rstn;
  logic [2:0] scMode, txIrqEnable, rxIrqEnable, txEndIrqEnable, txLoadEvt, txEndEvt, txErrEvt;
  logic [2:0] rxFullEvt, overrunEvt, parityEvt, framingEvt, errSignalEvt, clrTxEmpty, clrTxEnd;
  logic [2:0] clrRxFull, clrOverrun, clrParity, clrFraming, clrErrSignal, rxXferSel, txXferSel;
  logic [2:0] dmaSel, mTe, mTend, mRf, mOv, mPe, mFe, mEs, mRb, tA, rA;
  wire  [2:0] xferRxAck, xferTxAck, txBufferEmptyFlag, txEndFlag, rxBufferFullFlag;
  wire  [2:0] overrunErrorFlag, parityErrorFlag, framingErrorFlag, errorSignalFlag, resendBusy;
  wire  [2:0] rxErrorRequest, rxFullRequest, txEmptyRequest, txEndRequest, dataXferRxStart;
  wire  [2:0] dataXferTxStart, dmaRxStart, dmaTxStart, eRq, fRq, tRq, dRq;
  wire        irqValid_q;
  wire  [3:0] irqVector_q;
  logic [11:0] ePend;
  logic [3:0] eVec;
  logic [31:0] seed = 32'hc144e9ef;
  int fails = 0, comparisons = 0, cycles = 0;
  sir_top dut (.*);
  sir_xfer_model u_xfer (.*);
  always #4 clk_sys = ~clk_sys;
  // Expected requests from model flags and live enables
  assign eRq = rxIrqEnable & (mOv | mPe | (scMode & mEs) | (~scMode & mFe));
  assign fRq = mRf & rxIrqEnable;
  assign tRq = mTe & txIrqEnable;
  assign dRq = mTend & txEndIrqEnable & ~scMode;
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic tally(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s mismatch", $time, m);
    end
  endtask
  task automatic chk_flags;
    tally({txBufferEmptyFlag, txEndFlag, rxBufferFullFlag, overrunErrorFlag} ===
      {mTe, mTend, mRf, mOv}, "flags");
    tally({parityErrorFlag, framingErrorFlag, errorSignalFlag, resendBusy} ===
      {mPe, mFe, mEs, mRb}, "errs");
  endtask
  task automatic chk_reqs;
    tally({rxErrorRequest, rxFullRequest, txEmptyRequest, txEndRequest} ===
      {eRq, fRq, tRq, dRq}, "reqs");
    tally({dataXferRxStart, dmaRxStart, dataXferTxStart, dmaTxStart} ===
      {fRq & rxXferSel & ~(dmaSel & DOK), fRq & rxXferSel & dmaSel & DOK,
       tRq & txXferSel & ~(dmaSel & DOK), tRq & txXferSel & dmaSel & DOK}, "starts");
  endtask
  task automatic chk_irq;
    tally(irqValid_q === (ePend != 12'h000), "irq valid");
    if (ePend != 12'h000) tally(irqVector_q === eVec, "irq vector");
  endtask
  // Model step at a clock edge: set beats clear for every flag
  task automatic step;
    for (int i = 0; i < 3; i++) begin
      ePend[i*4 +: 4] = {dRq[i], tRq[i] & ~txXferSel[i], fRq[i] & ~rxXferSel[i], eRq[i]};
    end
    for (int i = 11; i >= 0; i--) if (ePend[i]) eVec = i[3:0];
    tA = xferTxAck & tRq & txXferSel;
    rA = xferRxAck & fRq & rxXferSel;
    mTe = (scMode & txEndEvt) | (~scMode & txLoadEvt) | (mTe & ~(clrTxEmpty | tA));
    mTend = txEndEvt | (mTend & ~(clrTxEnd | (scMode & (tA | txErrEvt | mRb))));
    mRb = (scMode & txErrEvt) | (mRb & ~txEndEvt);
    mRf = (rxFullEvt & ~(scMode & (parityEvt | overrunEvt)))
      | (mRf & ~(clrRxFull | rA));
    mOv = overrunEvt | (mOv & ~clrOverrun);
    mPe = parityEvt | (mPe & ~clrParity);
    mFe = framingEvt | (mFe & ~clrFraming);
    mEs = errSignalEvt | (mEs & ~clrErrSignal);
  endtask
  task automatic drive;
    logic [31:0] a, b, c, d, e;
    a = xs(seed);
    b = xs(a);
    c = xs(b);
    d = xs(c);
    seed = d;
    e = a & b;
    {txLoadEvt, txEndEvt, rxFullEvt, overrunEvt, parityEvt, framingEvt, errSignalEvt} = e[20:0];
    txErrEvt = e[23:21] & scMode & ~e[17:15];
    {clrTxEmpty, clrTxEnd, clrRxFull, clrOverrun, clrParity, clrFraming, clrErrSignal} =
      c[20:0] & d[20:0] & a[31:11];
    {txIrqEnable, rxIrqEnable, txEndIrqEnable} = c[31:23] | d[31:23];
  endtask
  task automatic do_reset(input logic [2:0] mode);
    rstn = 1'b0;
    {txIrqEnable, rxIrqEnable, txEndIrqEnable, txLoadEvt, txEndEvt, txErrEvt} = 18'h0;
    {rxFullEvt, overrunEvt} = 6'h0;
    {parityEvt, framingEvt, errSignalEvt, clrTxEmpty, clrTxEnd, clrRxFull, clrOverrun} = 21'h0;
    {clrParity, clrFraming, clrErrSignal} = 9'h0;
    scMode = mode;
    {mTe, mTend, mRf, mOv, mPe, mFe, mEs, mRb} = {6'h3f, 18'h0};
    repeat (20) @(posedge clk_sys);
    #1 rstn = 1'b1;
  endtask
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard: the run needs about 4600 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      complete_run();
    end
  end
  // Phases: normal mode, smart card mode, mixed modes and routes
  initial begin
    for (int p = 0; p < 3; p++) begin
      seed = xs(seed);
      {rxXferSel, txXferSel, dmaSel} = seed[11:3];
      do_reset(p == 0 ? 3'h0 : p == 1 ? 3'h7 : seed[14:12]);
      repeat (1500) begin
        @(posedge clk_sys);
        step();
        #1;
        chk_flags();
        chk_reqs();
        chk_irq();
        drive();
      end
      $display("test phase %0d done", p);
    end
    complete_run();
  end
endmodule // sir_tb_top
`default_nettype wire
